// [rtl/pss_pkg.sv]
// constants shared by the fault summary register block
package pss_pkg;
	// *****************************************************************
	// command codes and pages
	// *****************************************************************
	localparam logic [7:0]  CMD_SUMMARY_WORD = 8'h79;
	localparam logic [7:0]  CMD_SUMMARY_BYTE = 8'h78;
	localparam logic [7:0]  PAGE_CHAN_A      = 8'h00;
	localparam logic [7:0]  PAGE_CHAN_B      = 8'h01;
	localparam logic [7:0]  PAGE_ALL         = 8'hff;
	localparam logic [15:0] RSP_RESET        = 16'h0000;
	localparam int          CHAN_NUM         = 2;
	// *****************************************************************
	// detail flag vector positions
	// *****************************************************************
	localparam int DET_VOUT    = 0;
	localparam int DET_IOUT    = 1;
	localparam int DET_INPUT   = 2;
	localparam int DET_MFR     = 3;
	localparam int DET_VOUT_OV = 4;
	localparam int DET_IOUT_OC = 5;
	localparam int DET_VIN_UV  = 6;
	localparam int DET_TEMP    = 7;
	localparam int DET_CML     = 8;
	localparam int DET_OTHER   = 9;
	localparam int DET_W       = 10;
	// *****************************************************************
	// summary word bit positions
	// *****************************************************************
	localparam int BIT_VOUT    = 15;
	localparam int BIT_IOUT    = 14;
	localparam int BIT_INPUT   = 13;
	localparam int BIT_MFR     = 12;
	localparam int BIT_PGOOD   = 11;
	localparam int BIT_FANS    = 10;
	localparam int BIT_OTH_HI  = 9;
	localparam int BIT_UNKNOWN = 8;
	localparam int BIT_BUSY    = 7;
	localparam int BIT_OFF     = 6;
	localparam int BIT_VOUT_OV = 5;
	localparam int BIT_IOUT_OC = 4;
	localparam int BIT_VIN_UV  = 3;
	localparam int BIT_TEMP    = 2;
	localparam int BIT_CML     = 1;
	localparam int BIT_OTHER   = 0;
endpackage

// [rtl/pss_summary_build.sv]
// per-channel summary word built from detail flags
`timescale 1ns/1ps
module pss_summary_build
(
	input  wire logic [pss_pkg::DET_W-1:0] detail,
	input  wire logic                      readyPinSync,
	input  wire logic                      outputOn,
	output logic      [15:0]               summary
);
	// *****************************************************************
	// bit mapping, no storage
	// *****************************************************************
	always_comb
	begin
		summary = 16'h0000;
		summary[pss_pkg::BIT_VOUT]    = detail[pss_pkg::DET_VOUT];
		summary[pss_pkg::BIT_IOUT]    = detail[pss_pkg::DET_IOUT];
		summary[pss_pkg::BIT_INPUT]   = detail[pss_pkg::DET_INPUT];
		summary[pss_pkg::BIT_MFR]     = detail[pss_pkg::DET_MFR];
		summary[pss_pkg::BIT_PGOOD]   = ~readyPinSync;
		summary[pss_pkg::BIT_OFF]     = ~outputOn;
		summary[pss_pkg::BIT_VOUT_OV] = detail[pss_pkg::DET_VOUT_OV];
		summary[pss_pkg::BIT_IOUT_OC] = detail[pss_pkg::DET_IOUT_OC];
		summary[pss_pkg::BIT_VIN_UV]  = detail[pss_pkg::DET_VIN_UV];
		summary[pss_pkg::BIT_TEMP]    = detail[pss_pkg::DET_TEMP];
		summary[pss_pkg::BIT_CML]     = detail[pss_pkg::DET_CML];
		summary[pss_pkg::BIT_OTHER]   = detail[pss_pkg::DET_OTHER];
	end
endmodule

// [rtl/pss_status_summary.sv]
// paged fault summary registers with command decode and response
`timescale 1ns/1ps
module pss_status_summary
(
	input  wire logic                      sys_clk,
	input  wire logic                      reset,
	input  wire logic [7:0]                page,
	input  wire logic                      cmdValid,
	input  wire logic [7:0]                cmdCode,
	input  wire logic                      cmdRead,
	input  wire logic                      cmdWord,
	input  wire logic [pss_pkg::DET_W-1:0] detailA,
	input  wire logic [pss_pkg::DET_W-1:0] detailB,
	input  wire logic                      chanAReadyPin,
	input  wire logic                      chanBReadyPin,
	input  wire logic                      chanAOutputOn,
	input  wire logic                      chanBOutputOn,
	output logic                           rspValid,
	output logic      [15:0]               rspData,
	output logic                           invalidTxn
);
	// *****************************************************************
	// ready pin synchronisers
	// *****************************************************************
	logic [1:0]  readyMeta_r;
	logic [1:0]  readyMeta_nxt;
	logic [1:0]  readySync_r;
	logic [1:0]  readySync_nxt;

	always_comb
	begin
		readyMeta_nxt = {chanBReadyPin, chanAReadyPin};
		readySync_nxt = readyMeta_r;
	end

	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			readyMeta_r <= 2'h0;
			readySync_r <= 2'h0;
		end
		else
		begin
			readyMeta_r <= readyMeta_nxt;
			readySync_r <= readySync_nxt;
		end
	end

	// *****************************************************************
	// per-channel summary words
	// *****************************************************************
	logic [pss_pkg::DET_W-1:0] chanDetail [pss_pkg::CHAN_NUM];
	logic [15:0]               chanWord   [pss_pkg::CHAN_NUM];
	logic [1:0]                chanOn;

	always_comb
	begin
		chanDetail[0] = detailA;
		chanDetail[1] = detailB;
		chanOn        = {chanBOutputOn, chanAOutputOn};
	end

	genvar gc;
	generate
		for (gc = 0; gc < pss_pkg::CHAN_NUM; gc = gc + 1)
		begin : g_chan
			pss_summary_build u_build
			(
				.detail       (chanDetail[gc]),
				.readyPinSync (readySync_r[gc]),
				.outputOn     (chanOn[gc]),
				.summary      (chanWord[gc])
			);
		end
	endgenerate

	// *****************************************************************
	// page select
	// *****************************************************************
	logic [15:0] selWord;

	always_comb
	begin
		if (page == pss_pkg::PAGE_CHAN_B)
			selWord = chanWord[1];
		else
			selWord = chanWord[0];
	end

	// *****************************************************************
	// command decode and response
	// *****************************************************************
	logic        isWordCmd;
	logic        isByteCmd;
	logic        rspValid_r;
	logic        rspValid_nxt;
	logic [15:0] rspData_r;
	logic [15:0] rspData_nxt;
	logic        invalid_r;
	logic        invalid_nxt;

	always_comb
	begin
		isWordCmd    = cmdCode == pss_pkg::CMD_SUMMARY_WORD;
		isByteCmd    = cmdCode == pss_pkg::CMD_SUMMARY_BYTE;
		rspValid_nxt = 1'b0;
		rspData_nxt  = rspData_r;
		invalid_nxt  = 1'b0;
		if (cmdValid && (isWordCmd || isByteCmd))
		begin
			if (!cmdRead)
				invalid_nxt = 1'b1;
			else if (isWordCmd && cmdWord)
			begin
				rspValid_nxt = 1'b1;
				rspData_nxt  = selWord;
			end
			else if (isByteCmd && !cmdWord)
			begin
				rspValid_nxt = 1'b1;
				rspData_nxt  = {8'h00, selWord[7:0]};
			end
			else
				invalid_nxt = 1'b1;
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			rspValid_r <= 1'b0;
			rspData_r  <= pss_pkg::RSP_RESET;
			invalid_r  <= 1'b0;
		end
		else
		begin
			rspValid_r <= rspValid_nxt;
			rspData_r  <= rspData_nxt;
			invalid_r  <= invalid_nxt;
		end
	end

	assign rspValid   = rspValid_r;
	assign rspData    = rspData_r;
	assign invalidTxn = invalid_r;

	// *****************************************************************
	// checks
	// *****************************************************************
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);

	sequence wordRead_s;
		cmdValid && cmdRead && cmdWord && isWordCmd;
	endsequence

	sequence byteRead_s;
		cmdValid && cmdRead && !cmdWord && isByteCmd;
	endsequence

	word_read_a: assert property (wordRead_s |=> rspValid && !invalidTxn
		&& rspData == $past(selWord))
		else $error("word summary read wrong");
	byte_match_a: assert property (byteRead_s |=> rspValid
		&& rspData == {8'h00, $past(selWord[7:0])})
		else $error("byte summary differs from word low byte");
	write_reject_a: assert property (cmdValid && !cmdRead
		&& (isWordCmd || isByteCmd) |=> invalidTxn && !rspValid
		&& $stable(rspData))
		else $error("summary write not rejected");
	byte_word_a: assert property (cmdValid && cmdRead && !cmdWord
		&& isWordCmd |=> invalidTxn && !rspValid)
		else $error("word summary read as byte not rejected");
	page_ffh_a: assert property (page == pss_pkg::PAGE_ALL
		|-> selWord == chanWord[0])
		else $error("page ffh not channel a");
	page_b_a: assert property (page == pss_pkg::PAGE_CHAN_B
		|-> selWord == chanWord[1])
		else $error("page 01h not channel b");
	pgood_mirror_a: assert property (!$past(reset, 2) |->
		chanWord[0][pss_pkg::BIT_PGOOD] == !$past(chanAReadyPin, 2))
		else $error("power good does not mirror ready pin");
	unsup_zero_a: assert property (selWord[10:7] == 4'h0)
		else $error("unsupported bit set");
	cml_bit_a: assert property (chanWord[1][pss_pkg::BIT_CML]
		== detailB[pss_pkg::DET_CML])
		else $error("cml bit mismatch");
	other_bit_a: assert property (chanWord[0][pss_pkg::BIT_OTHER]
		== detailA[pss_pkg::DET_OTHER])
		else $error("other bit mismatch");
	off_bit_a: assert property (chanWord[1][pss_pkg::BIT_OFF]
		== !chanBOutputOn)
		else $error("off bit mismatch");
	oc_clear_a: assert property ($fell(detailA[pss_pkg::DET_IOUT_OC])
		|-> !chanWord[0][pss_pkg::BIT_IOUT_OC])
		else $error("overcurrent summary not cleared");
	vout_map_a: assert property (chanWord[0][15:12] == {detailA[0],
		detailA[1], detailA[2], detailA[3]})
		else $error("upper byte mapping wrong");
	low_map_a: assert property (chanWord[1][5:2] == {detailB[4],
		detailB[5], detailB[6], detailB[7]})
		else $error("lower byte mapping wrong");
	no_state_a: assert property ($stable(detailA) && $stable(readySync_r)
		&& $stable(chanAOutputOn) |-> $stable(chanWord[0]))
		else $error("summary holds own state");
	word_byte_a: assert property (cmdValid && cmdRead && cmdWord
		&& isByteCmd |=> invalidTxn && !rspValid && $stable(rspData))
		else $error("byte summary read as word not rejected");
	unknown_quiet_a: assert property (cmdValid && !isWordCmd
		&& !isByteCmd |=> !rspValid && !invalidTxn && $stable(rspData))
		else $error("unknown code answered");
	pgood_b_a: assert property (!$past(reset, 2) |->
		chanWord[1][pss_pkg::BIT_PGOOD] == !$past(chanBReadyPin, 2))
		else $error("power good b does not mirror ready pin");
	chan_off_a: assert property (chanWord[0][pss_pkg::BIT_OFF]
		== !chanAOutputOn)
		else $error("off bit mismatch on channel a");
	cml_first_a: assert property (chanWord[0][pss_pkg::BIT_CML]
		== detailA[pss_pkg::DET_CML])
		else $error("cml bit mismatch on channel a");
endmodule

// [dv/pss_detail_model.sv]
// detail flag registers standing in for the category status registers
`timescale 1ns/1ps
module pss_detail_model
(
	input  wire logic                      sys_clk,
	input  wire logic                      reset,
	input  wire logic [pss_pkg::DET_W-1:0] setA,
	input  wire logic [pss_pkg::DET_W-1:0] setB,
	input  wire logic [pss_pkg::DET_W-1:0] clrA,
	input  wire logic [pss_pkg::DET_W-1:0] clrB,
	output logic      [pss_pkg::DET_W-1:0] detailA,
	output logic      [pss_pkg::DET_W-1:0] detailB
);
	// *****************************************************************
	// latched flags, cleared by writing one
	// *****************************************************************
	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			detailA <= '0;
			detailB <= '0;
		end
		else
		begin
			detailA <= (detailA & ~clrA) | setA;
			detailB <= (detailB & ~clrB) | setB;
		end
	end
endmodule

// [dv/tb_top.sv]
// self-checking bench for the fault summary registers
`timescale 1ns/1ps
module tb_top;
	// *****************************************************************
	// signals
	// *****************************************************************
	logic                      sys_clk, reset, cmdValid, cmdRead, cmdWord;
	logic [7:0]                page, cmdCode;
	logic [pss_pkg::DET_W-1:0] setA, setB, clrA, clrB, fa, fb;
	logic [pss_pkg::DET_W-1:0] detailA, detailB;
	logic                      pinA, pinB, onA, onB;
	logic                      rspValid, invalidTxn;
	logic [15:0]               rspData, hold, e;
	int                        errTotal, checks, cyc;

	pss_detail_model model (.sys_clk(sys_clk), .reset(reset), .setA(setA),
		.setB(setB), .clrA(clrA), .clrB(clrB), .detailA(detailA),
		.detailB(detailB));
	pss_status_summary dut (.sys_clk(sys_clk), .reset(reset), .page(page),
		.cmdValid(cmdValid), .cmdCode(cmdCode), .cmdRead(cmdRead),
		.cmdWord(cmdWord), .detailA(detailA), .detailB(detailB),
		.chanAReadyPin(pinA), .chanBReadyPin(pinB), .chanAOutputOn(onA),
		.chanBOutputOn(onB), .rspValid(rspValid), .rspData(rspData),
		.invalidTxn(invalidTxn));

	// *****************************************************************
	// helpers
	// *****************************************************************
	function automatic logic [15:0] expWord(logic [9:0] d, logic pin,
		logic on);
		return {d[0], d[1], d[2], d[3], ~pin, 4'h0, ~on, d[4], d[5], d[6],
			d[7], d[8], d[9]};
	endfunction

	task results;
		if (errTotal == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task chk(input logic ok, input string msg);
		checks++;
		if (ok !== 1'b1)
		begin
			errTotal++;
			$display("[FAIL] %0t %s", $time, msg);
		end
	endtask

	task req(input logic [7:0] c, input logic rd, input logic wd,
		input logic [7:0] pg);
		hold = rspData;
		@(posedge sys_clk);
		cmdValid <= 1'b1;
		cmdCode  <= c;
		cmdRead  <= rd;
		cmdWord  <= wd;
		page     <= pg;
		@(posedge sys_clk);
		cmdValid <= 1'b0;
		#1;
	endtask

	task rdChk(input logic [7:0] c, input logic wd, input logic [7:0] pg,
		input logic [15:0] x);
		req(c, 1'b1, wd, pg);
		chk(rspValid === 1'b1 && invalidTxn === 1'b0 && rspData === x,
			"read data");
	endtask

	task badChk(input logic [7:0] c, input logic rd, input logic wd);
		req(c, rd, wd, 8'h00);
		chk(invalidTxn === 1'b1 && rspValid === 1'b0 && rspData === hold,
			"refused access");
	endtask

	task drive(input logic [9:0] sa, input logic [9:0] sb,
		input logic [9:0] ca, input logic [9:0] cb, input logic [3:0] p);
		@(posedge sys_clk);
		setA <= sa;
		setB <= sb;
		clrA <= ca;
		clrB <= cb;
		{pinA, pinB, onA, onB} <= p;
		@(posedge sys_clk);
		setA <= '0;
		setB <= '0;
		clrA <= '0;
		clrB <= '0;
		fa = (fa & ~ca) | sa;
		fb = (fb & ~cb) | sb;
		repeat (3) @(posedge sys_clk);
		#1;
	endtask

	// *****************************************************************
	// clock, timeout and tests
	// *****************************************************************
	initial
	begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end

	always @(posedge sys_clk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			errTotal++;
			results;
		end
	end

	initial
	begin
		{reset, cmdValid, cmdRead, cmdWord} = 4'h8;
		{page, cmdCode} = 16'h0000;
		{setA, setB, clrA, clrB, fa, fb} = '0;
		{pinA, pinB, onA, onB} = 4'hf;
		{errTotal, checks, cyc} = '0;
		repeat (6) @(posedge sys_clk);
		reset <= 1'b0;
		@(posedge sys_clk);
		#1;
		chk(rspValid === 1'b0 && invalidTxn === 1'b0 && rspData === 16'h0000,
			"reset outputs");
		for (int i = 0; i < 10; i++)
		begin
			drive(10'h1 << i, 10'h200 >> i, '0, '0,
				{i[0], ~i[0], i[1], ~i[1]});
			e = expWord(fa, pinA, onA);
			rdChk(8'h79, 1'b1, 8'h00, e);
			rdChk(8'h79, 1'b1, 8'hff, e);
			rdChk(8'h78, 1'b0, 8'h00, {8'h00, e[7:0]});
			rdChk(8'h79, 1'b1, 8'h01, expWord(fb, pinB, onB));
			drive('0, '0, 10'h1 << i, 10'h200 >> i, {pinA, pinB, onA, onB});
			rdChk(8'h79, 1'b1, 8'h00, expWord(fa, pinA, onA));
			rdChk(8'h79, 1'b1, 8'h01, expWord(fb, pinB, onB));
		end
		drive(10'h100, '0, '0, '0, 4'h5);
		badChk(8'h78, 1'b0, 1'b0);
		badChk(8'h79, 1'b0, 1'b1);
		badChk(8'h79, 1'b1, 1'b0);
		badChk(8'h78, 1'b1, 1'b1);
		e = expWord(fa, pinA, onA);
		rdChk(8'h78, 1'b0, 8'h00, {8'h00, e[7:0]});
		req(8'h7a, 1'b1, 1'b1, 8'h00);
		chk(rspValid === 1'b0 && invalidTxn === 1'b0, "unknown code");
		results;
	end
endmodule
